// File: hw/adcct_regs.sv
`timescale 1ns/1ps
// How it works
// - Program registers except the channel index write to a shadow copy and change the working copy only when a write sets transfer bit 0, which self-clears.
// - The test-mode register exists once per channel and a write lands in every channel whose select bit is set in the channel index register.
// - The three-bit divider field divides the input clock by its value plus one, resetting to divide by one.
// - Test codes 0 to 3 give normal data, midscale, positive full scale and negative full scale.
// - Codes 4 to 6 give a checkerboard, the 23-stage and the 9-stage pseudorandom sequences.
// - Codes 7 to 9 give whole-word toggling, the user pattern and alternate-bit toggling.
// - Codes 10 to 12 give the sync pattern, a single high bit and a mixed bit frequency pattern.
module adcct_regs #(
  parameter int BIST_LEN = 256,
  parameter logic [9:0] USER_PATTERN = 10'h155,
  parameter logic [9:0] SYNC_WORD = 10'h3e0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  input wire logic [adcct_pkg::SAMPLE_W-1:0] conv_a,
  input wire logic [adcct_pkg::SAMPLE_W-1:0] conv_b,
  output logic [adcct_pkg::SAMPLE_W-1:0] chan_a_out,
  output logic [adcct_pkg::SAMPLE_W-1:0] chan_b_out,
  output logic sample_strobe,
  output logic dcs_enable,
  output logic [7:0] operating_mode,
  output logic bist_busy,
  output logic [adcct_pkg::SIG_W-1:0] bist_signature
);
  import adcct_pkg::*;

  if (BIST_LEN < 1 || BIST_LEN > 65536) begin : g_bad_len
    $error("adcct_regs: BIST_LEN must lie in 1..65536");
  end

  // Three-stage pin synchronisers, filtered levels
  logic [2:0] csb_sr_q, sclk_sr_q, sdio_sr_q;
  logic csb_f_q, csb_f_d, sclk_f_q, sclk_f_d, sdio_f_q, sdio_f_d;
  logic sclk_rise;

  // A level only changes once the second and third stages agree
  always_comb begin
    csb_f_d = (csb_sr_q[1] == csb_sr_q[2]) ? csb_sr_q[2] : csb_f_q;
    sclk_f_d = (sclk_sr_q[1] == sclk_sr_q[2]) ? sclk_sr_q[2] : sclk_f_q;
    sdio_f_d = (sdio_sr_q[1] == sdio_sr_q[2]) ? sdio_sr_q[2] : sdio_f_q;
    sclk_rise = sclk_f_d & ~sclk_f_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      csb_sr_q <= 3'h7;
      sclk_sr_q <= 3'h0;
      sdio_sr_q <= 3'h0;
      csb_f_q <= 1'b1;
      sclk_f_q <= 1'b0;
      sdio_f_q <= 1'b0;
    end else begin
      csb_sr_q <= {csb_sr_q[1:0], spi_csb_n};
      sclk_sr_q <= {sclk_sr_q[1:0], spi_sclk};
      sdio_sr_q <= {sdio_sr_q[1:0], spi_sdio_i};
      csb_f_q <= csb_f_d;
      sclk_f_q <= sclk_f_d;
      sdio_f_q <= sdio_f_d;
    end
  end

  // Register state: shadow copies, working copies and index
  logic [1:0] chan_idx_q, chan_idx_d;
  logic [7:0] modes_s_q, modes_s_d, modes_a_q, modes_a_d;
  logic [7:0] clock_s_q, clock_s_d, clock_a_q, clock_a_d;
  logic [7:0] div_s_q, div_s_d, div_a_q, div_a_d;
  logic [1:0][7:0] test_s_q, test_s_d, test_a_q, test_a_d;
  logic [7:0] bist_s_q, bist_s_d, bist_a_q, bist_a_d;
  logic xfer_q, xfer_d;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;

  // Read view shows the shadow copy; both channels set reads channel A
  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CHAN_IDX: rd_mux = {6'h00, chan_idx_q};
      ADDR_MODES: rd_mux = modes_s_q;
      ADDR_CLOCK: rd_mux = clock_s_q;
      ADDR_CLK_DIV: rd_mux = div_s_q;
      ADDR_TEST: rd_mux = chan_idx_q[CHAN_A_BIT] ? test_s_q[0] : test_s_q[1];
      ADDR_BIST: rd_mux = bist_s_q;
      ADDR_XFER: rd_mux = {7'h00, xfer_q};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Serial engine: 16-bit instruction, then bytes with falling address
  adcct_spi_state_t sp_q, sp_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [14:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] out_sh_q, out_sh_d;
  logic sdio_o_d, sdio_oe_d;
  logic [7:0] rbyte;

  always_comb begin
    sp_d = sp_q;
    bit_cnt_d = bit_cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    addr_d = addr_q;
    out_sh_d = out_sh_q;
    sdio_o_d = spi_sdio_o;
    sdio_oe_d = spi_sdio_oe;
    wr_en = 1'b0;
    wr_addr = addr_q;
    wr_data = {sh_q[6:0], sdio_f_d};
    rbyte = 8'h00;
    if (csb_f_d) begin
      sp_d = SP_IDLE;
      sdio_oe_d = 1'b0;
    end else begin
      case (sp_q)
        SP_IDLE: begin
          sp_d = SP_INSTR;
          bit_cnt_d = 4'h0;
        end
        SP_INSTR: if (sclk_rise) begin
          sh_d = {sh_q[13:0], sdio_f_d};
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'(INSTR_BITS - 1)) begin
            rd_d = sh_q[INSTR_RD_BIT-1];
            addr_d = {sh_q[11:0], sdio_f_d};
            bit_cnt_d = 4'h0;
            sp_d = SP_DATA;
            if (sh_q[INSTR_RD_BIT-1]) begin
              rbyte = rd_mux({sh_q[11:0], sdio_f_d});
              sdio_o_d = rbyte[7];
              out_sh_d = {rbyte[6:0], 1'b0};
              sdio_oe_d = 1'b1;
            end
          end
        end
        SP_DATA: if (sclk_rise) begin
          sh_d = {sh_q[13:0], sdio_f_d};
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'(DATA_W - 1)) begin
            bit_cnt_d = 4'h0;
            addr_d = addr_q - 1'b1;
            wr_en = ~rd_q;
            if (rd_q) begin
              rbyte = rd_mux(addr_q - 1'b1);
              sdio_o_d = rbyte[7];
              out_sh_d = {rbyte[6:0], 1'b0};
            end
          end else if (rd_q) begin
            sdio_o_d = out_sh_q[7];
            out_sh_d = {out_sh_q[6:0], 1'b0};
          end
        end
        default: sp_d = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sp_q <= SP_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q <= 15'h0000;
      rd_q <= 1'b0;
      addr_q <= '0;
      out_sh_q <= 8'h00;
      spi_sdio_o <= 1'b0;
      spi_sdio_oe <= 1'b0;
    end else begin
      sp_q <= sp_d;
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      out_sh_q <= out_sh_d;
      spi_sdio_o <= sdio_o_d;
      spi_sdio_oe <= sdio_oe_d;
    end
  end

  // Host writes land in shadows, the channel index directly; a pending transfer copies the shadows over
  always_comb begin
    chan_idx_d = chan_idx_q;
    modes_s_d = modes_s_q;
    clock_s_d = clock_s_q;
    div_s_d = div_s_q;
    test_s_d = test_s_q;
    bist_s_d = bist_s_q;
    modes_a_d = modes_a_q;
    clock_a_d = clock_a_q;
    div_a_d = div_a_q;
    test_a_d = test_a_q;
    bist_a_d = bist_a_q;
    xfer_d = xfer_q;
    if (xfer_q) begin
      modes_a_d = modes_s_q;
      clock_a_d = clock_s_q;
      div_a_d = div_s_q;
      test_a_d = test_s_q;
      bist_a_d = bist_s_q;
      xfer_d = 1'b0;
    end
    if (wr_en) begin
      case (wr_addr)
        ADDR_CHAN_IDX: chan_idx_d = wr_data[1:0];
        ADDR_MODES: modes_s_d = wr_data;
        ADDR_CLOCK: clock_s_d = wr_data;
        ADDR_CLK_DIV: div_s_d = wr_data;
        ADDR_TEST: begin
          if (chan_idx_q[CHAN_A_BIT]) test_s_d[0] = wr_data;
          if (chan_idx_q[CHAN_B_BIT]) test_s_d[1] = wr_data;
        end
        ADDR_BIST: bist_s_d = wr_data;
        // A new request in the clearing cycle still wins
        ADDR_XFER: if (wr_data[XFER_BIT]) xfer_d = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chan_idx_q <= RST_CHAN_IDX;
      modes_s_q <= RST_MODES;
      clock_s_q <= RST_CLOCK;
      div_s_q <= RST_CLK_DIV;
      test_s_q <= {RST_TEST, RST_TEST};
      bist_s_q <= RST_BIST;
      modes_a_q <= RST_MODES;
      clock_a_q <= RST_CLOCK;
      div_a_q <= RST_CLK_DIV;
      test_a_q <= {RST_TEST, RST_TEST};
      bist_a_q <= RST_BIST;
      xfer_q <= 1'b0;
    end else begin
      chan_idx_q <= chan_idx_d;
      modes_s_q <= modes_s_d;
      clock_s_q <= clock_s_d;
      div_s_q <= div_s_d;
      test_s_q <= test_s_d;
      bist_s_q <= bist_s_d;
      modes_a_q <= modes_a_d;
      clock_a_q <= clock_a_d;
      div_a_q <= div_a_d;
      test_a_q <= test_a_d;
      bist_a_q <= bist_a_d;
      xfer_q <= xfer_d;
    end
  end

  // Clock divider and self-test signature
  localparam int BCW = $clog2(BIST_LEN + 1);
  logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
  logic strobe_d;
  logic busy_d;
  logic [BCW-1:0] bcnt_q, bcnt_d;
  logic [SIG_W-1:0] sig_d;
  logic bist_start;

  always_comb begin
    // Strobe every field+1 input clocks; zero gives every clock
    strobe_d = 1'b0;
    div_cnt_d = div_cnt_q + 1'b1;
    if (div_cnt_q >= div_a_q[DIV_W-1:0]) begin
      div_cnt_d = '0;
      strobe_d = 1'b1;
    end
    // Self-test starts when the working enable bit goes high
    bist_start = xfer_q & bist_s_q[BIST_EN_BIT] & ~bist_a_q[BIST_EN_BIT];
    busy_d = bist_busy;
    bcnt_d = bcnt_q;
    sig_d = bist_signature;
    if (bist_start) begin
      busy_d = 1'b1;
      bcnt_d = '0;
      if (bist_s_q[BIST_SEED_BIT]) sig_d = SIG_SEED;
    end else if (bist_busy && sample_strobe) begin
      // Signature folds in channel A output so test patterns show up
      sig_d = {bist_signature[SIG_W-2:0],
               bist_signature[15] ^ bist_signature[12] ^
               bist_signature[3] ^ bist_signature[1]} ^
              {{(SIG_W-SAMPLE_W){1'b0}}, chan_a_out};
      bcnt_d = bcnt_q + 1'b1;
      if (bcnt_q == BCW'(BIST_LEN - 1)) busy_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_cnt_q <= '0;
      sample_strobe <= 1'b0;
      bist_busy <= 1'b0;
      bcnt_q <= '0;
      bist_signature <= SIG_SEED;
      dcs_enable <= 1'b0;
      operating_mode <= RST_MODES;
    end else begin
      div_cnt_q <= div_cnt_d;
      sample_strobe <= strobe_d;
      bist_busy <= busy_d;
      bcnt_q <= bcnt_d;
      bist_signature <= sig_d;
      dcs_enable <= clock_a_q[DCS_BIT];
      operating_mode <= modes_a_q;
    end
  end

  // One pattern generator per channel, driven by its working copy
  adcct_test_cfg_t cfg_a, cfg_b;
  assign cfg_a = '{mode: test_a_q[0][TEST_MODE_W-1:0],
                   pn_long_rst: test_a_q[0][PN_LONG_RST_BIT],
                   pn_short_rst: test_a_q[0][PN_SHORT_RST_BIT]};
  assign cfg_b = '{mode: test_a_q[1][TEST_MODE_W-1:0],
                   pn_long_rst: test_a_q[1][PN_LONG_RST_BIT],
                   pn_short_rst: test_a_q[1][PN_SHORT_RST_BIT]};

  adcct_pattern #(.W(SAMPLE_W), .USER_PATTERN(USER_PATTERN),
                  .SYNC_WORD(SYNC_WORD)) u_pat_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .sample_en(sample_strobe),
    .cfg(cfg_a),
    .conv_data(conv_a),
    .data_q(chan_a_out)
  );

  adcct_pattern #(.W(SAMPLE_W), .USER_PATTERN(USER_PATTERN),
                  .SYNC_WORD(SYNC_WORD)) u_pat_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .sample_en(sample_strobe),
    .cfg(cfg_b),
    .conv_data(conv_b),
    .data_q(chan_b_out)
  );
endmodule

// File: hw/adcct_pkg.sv
package adcct_pkg;
  // Serial port framing
  localparam int ADDR_W = 13;
  localparam int INSTR_BITS = 16;
  localparam int DATA_W = 8;
  localparam int INSTR_RD_BIT = 15;
  localparam int SAMPLE_W = 10;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CHAN_IDX = 13'h005;
  localparam logic [ADDR_W-1:0] ADDR_MODES = 13'h008;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK = 13'h009;
  localparam logic [ADDR_W-1:0] ADDR_CLK_DIV = 13'h00b;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 13'h00d;
  localparam logic [ADDR_W-1:0] ADDR_BIST = 13'h00e;
  localparam logic [ADDR_W-1:0] ADDR_XFER = 13'h0ff;

  // Reset values
  localparam logic [1:0] RST_CHAN_IDX = 2'h3;
  localparam logic [7:0] RST_MODES = 8'h80;
  localparam logic [7:0] RST_CLOCK = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_BIST = 8'h00;

  // Field positions
  localparam int XFER_BIT = 0;
  localparam int CHAN_A_BIT = 0;
  localparam int CHAN_B_BIT = 1;
  localparam int DCS_BIT = 0;
  localparam int DIV_W = 3;
  localparam int TEST_MODE_W = 4;
  localparam int PN_SHORT_RST_BIT = 4;
  localparam int PN_LONG_RST_BIT = 5;
  localparam int BIST_EN_BIT = 0;
  localparam int BIST_SEED_BIT = 2;

  // Self-test signature generator
  localparam int SIG_W = 16;
  localparam logic [15:0] SIG_SEED = 16'hffff;

  // Output test pattern codes
  typedef enum logic [3:0] {
    TM_OFF = 4'h0,
    TM_MIDSCALE = 4'h1,
    TM_POS_FS = 4'h2,
    TM_NEG_FS = 4'h3,
    TM_CHECKER = 4'h4,
    TM_PN_LONG = 4'h5,
    TM_PN_SHORT = 4'h6,
    TM_WORD_TOGGLE = 4'h7,
    TM_USER = 4'h8,
    TM_BIT_TOGGLE = 4'h9,
    TM_SYNC = 4'ha,
    TM_ONE_BIT = 4'hb,
    TM_MIXED_FREQ = 4'hc
  } adcct_test_mode_t;

  // Per-channel pattern settings
  typedef struct packed {
    logic [3:0] mode;
    logic pn_long_rst;
    logic pn_short_rst;
  } adcct_test_cfg_t;

  // Serial engine states, Gray along the usual path
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_INSTR = 2'b01,
    SP_DATA = 2'b11
  } adcct_spi_state_t;
endpackage

// File: hw/adcct_pattern.sv
`timescale 1ns/1ps
module adcct_pattern #(
  parameter int W = 10,
  parameter logic [W-1:0] USER_PATTERN = '0,
  parameter logic [W-1:0] SYNC_WORD = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sample_en,
  input wire adcct_pkg::adcct_test_cfg_t cfg,
  input wire logic [W-1:0] conv_data,
  output logic [W-1:0] data_q
);
  import adcct_pkg::*;

  if (W < 2 || W > 23) begin : g_bad_width
    $error("adcct_pattern: W must lie in 2..23");
  end

  logic [22:0] pn23_q, pn23_d;
  logic [8:0] pn9_q, pn9_d;
  logic tog_q, tog_d;
  logic [W-1:0] walk_q, walk_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] data_d;
  logic [W-1:0] chk_word;
  logic [W-1:0] pn9_word;

  // Generators step once per output sample
  always_comb begin
    pn23_d = pn23_q;
    pn9_d = pn9_q;
    tog_d = tog_q;
    walk_d = walk_q;
    cnt_d = cnt_q;
    if (sample_en) begin
      pn23_d = {pn23_q[21:0], pn23_q[22] ^ pn23_q[17]};
      pn9_d = {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
      tog_d = ~tog_q;
      walk_d = {walk_q[W-2:0], walk_q[W-1]};
      cnt_d = cnt_q + 1'b1;
    end
    // Reset bits hold the sequence at its seed while set
    if (cfg.pn_long_rst) pn23_d = '1;
    if (cfg.pn_short_rst) pn9_d = '1;
  end

  // Checkerboard alternates 0101.. and 1010..
  always_comb begin
    for (int i = 0; i < W; i++) begin
      chk_word[i] = tog_q ^ i[0];
    end
  end

  // PN9 word padded or cut at elaboration, so no out-of-range select exists
  if (W > 9) begin : g_pn9_pad
    assign pn9_word = {pn9_q, {(W-9){1'b0}}};
  end else begin : g_pn9_cut
    assign pn9_word = pn9_q[8 -: W];
  end

  // Test data replaces conversion data when a code is selected
  always_comb begin
    case (adcct_test_mode_t'(cfg.mode))
      TM_OFF: data_d = conv_data;
      TM_MIDSCALE: data_d = {1'b1, {(W-1){1'b0}}};
      TM_POS_FS: data_d = '1;
      TM_NEG_FS: data_d = '0;
      TM_CHECKER: data_d = chk_word;
      TM_PN_LONG: data_d = pn23_q[22 -: W];
      TM_PN_SHORT: data_d = pn9_word;
      TM_WORD_TOGGLE: data_d = {W{tog_q}};
      TM_USER: data_d = USER_PATTERN;
      TM_BIT_TOGGLE: data_d = chk_word;
      TM_SYNC: data_d = SYNC_WORD;
      TM_ONE_BIT: data_d = walk_q;
      TM_MIXED_FREQ: data_d = cnt_q;
      default: data_d = conv_data;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pn23_q <= '1;
      pn9_q <= '1;
      tog_q <= 1'b0;
      walk_q <= {{(W-1){1'b0}}, 1'b1};
      cnt_q <= '0;
      data_q <= '0;
    end else begin
      pn23_q <= pn23_d;
      pn9_q <= pn9_d;
      tog_q <= tog_d;
      walk_q <= walk_d;
      cnt_q <= cnt_d;
      data_q <= data_d;
    end
  end
endmodule

// File: tb/adcct_regs_assertions.sv
`timescale 1ns/1ps
module adcct_regs_assertions #(
  parameter int BIST_LEN = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_o,
  input wire logic spi_sdio_oe,
  input wire logic [9:0] chan_a_out,
  input wire logic dcs_enable,
  input wire logic [7:0] operating_mode,
  input wire logic bist_busy,
  input wire logic [15:0] bist_signature
);
  // Longest run: every strobe at divide by 8, plus start-up slack
  localparam int MAXB = BIST_LEN * 8 + 8;
  int busy_q;
  int busy_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Length of the current self-test run
  always_comb begin
    busy_d = bist_busy ? busy_q + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    busy_q <= srst ? 0 : busy_d;
  end

  property p_reset_vals;
    $fell(srst) |-> operating_mode == 8'h80 && !dcs_enable && !bist_busy &&
      bist_signature == 16'hffff && chan_a_out == 10'h000 && !spi_sdio_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  // Working copies only move on a transfer, which needs an open frame
  property p_apply_in_frame;
    ($changed(operating_mode) || $changed(dcs_enable)) |-> !spi_csb_n;
  endproperty
  a_apply_in_frame: assert property (p_apply_in_frame)
    else $error("working copy changed outside a frame");
  property p_bist_start;
    $rose(bist_busy) |-> !spi_csb_n;
  endproperty
  a_bist_start: assert property (p_bist_start)
    else $error("self-test started without a transfer");
  property p_bist_bound;
    busy_q <= MAXB;
  endproperty
  a_bist_bound: assert property (p_bist_bound)
    else $error("self-test runs too long");
  property p_sig_quiet;
    $changed(bist_signature) |-> bist_busy || $past(bist_busy) || !spi_csb_n;
  endproperty
  a_sig_quiet: assert property (p_sig_quiet)
    else $error("signature moved while idle");
  property p_oe_idle;
    spi_csb_n [*8] |-> !spi_sdio_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("sdio driven outside a frame");
  property p_oe_in_frame;
    $rose(spi_sdio_oe) |-> !spi_csb_n;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame)
    else $error("sdio drive began with select high");
  property p_oe_holds;
    spi_sdio_oe && !spi_csb_n |=> spi_sdio_oe;
  endproperty
  a_oe_holds: assert property (p_oe_holds)
    else $error("sdio drive dropped inside frame");
  // With sclk low this long no rise can be taken
  property p_sdo_hold;
    (!spi_sclk) [*6] |-> $stable(spi_sdio_o);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("read bit changed without a clock rise");
  c_bist: cover property ($rose(bist_busy));
  c_read: cover property ($rose(spi_sdio_oe));
  c_mode: cover property ($changed(operating_mode));
endmodule

bind adcct_regs adcct_regs_assertions #(.BIST_LEN(BIST_LEN)) chk (
  .ref_clk(ref_clk), .srst(srst), .spi_csb_n(spi_csb_n),
  .spi_sclk(spi_sclk), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe),
  .chan_a_out(chan_a_out), .dcs_enable(dcs_enable),
  .operating_mode(operating_mode), .bist_busy(bist_busy),
  .bist_signature(bist_signature));

// File: tb/adcct_host.sv
`timescale 1ns/1ps
module adcct_host (
  input wire logic ref_clk,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  output logic csb_n,
  output logic sclk,
  output logic sdio
);
  logic hd;
  logic he;
  logic last;
  initial begin
    csb_n = 1'h1;
    sclk = 1'h0;
    hd = 1'h0;
    he = 1'h1;
    last = 1'h0;
  end
  // Released line shows a toggling level, never a held stale bit
  always_comb sdio = sdio_oe ? sdio_o : he ? hd : ~last;
  always @(posedge ref_clk) last <= sdio;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Six clocks per phase, above the four the synchronisers need
  task automatic bit_io(input logic b, output logic r);
    hd = b;
    tick(6);
    r = sdio;
    sclk = 1'h1;
    tick(6);
    sclk = 1'h0;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a,
      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] ins;
    logic r;
    ins = {rd, 2'h0, a};
    csb_n = 1'h0;
    he = 1'h1;
    tick(4);
    for (int i = 15; i >= 0; i--) bit_io(ins[i], r);
    he = !rd;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    tick(12);
    csb_n = 1'h1;
    he = 1'h1;
    tick(12);
  endtask
endmodule

// File: tb/adcct_regs_bench.sv
`timescale 1ns/1ps
module adcct_regs_bench;
  import adcct_pkg::*;
  logic ref_clk, srst, csb, sclk, sdi, sdo, oe, strobe, dcs, busy, seen;
  logic [9:0] ca, cb, a_out, b_out, last_a, last_b, p;
  logic [7:0] mode, v, q;
  logic [15:0] sig, s1;
  int n_fail, check_count, cyc, n;

  adcct_regs #(.BIST_LEN(4), .USER_PATTERN(10'h155), .SYNC_WORD(10'h3e0))
    uut (.ref_clk(ref_clk), .srst(srst),
    .spi_csb_n(csb), .spi_sclk(sclk), .spi_sdio_i(sdi), .spi_sdio_o(sdo),
    .spi_sdio_oe(oe), .conv_a(ca), .conv_b(cb), .chan_a_out(a_out),
    .chan_b_out(b_out), .sample_strobe(strobe), .dcs_enable(dcs),
    .operating_mode(mode), .bist_busy(busy), .bist_signature(sig));
  adcct_host host (.ref_clk(ref_clk), .sdio_o(sdo), .sdio_oe(oe),
    .csb_n(csb), .sclk(sclk), .sdio(sdi));

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Fresh conversion data each clock; remember what the edge saw
  always @(posedge ref_clk) begin
    last_a <= ca;
    last_b <= cb;
    if (busy === 1'h1) seen <= 1'h1;
    #1 ca = 10'($urandom);
    cb = 10'($urandom);
  end
  // Hang guard, well above the planned run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("fails %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'h0, a, d, q);
  endtask
  task automatic rd(input logic [12:0] a);
    host.xfer(1'h1, a, 8'h00, q);
  endtask
  task automatic apply(input logic [12:0] a, input logic [7:0] d);
    wr(a, d);
    wr(ADDR_XFER, 8'h01);
  endtask
  // Fixed output for the constant test codes, offset binary
  function automatic logic [9:0] tm_exp(input int c);
    case (c)
      1: return 10'h200;
      2: return 10'h3ff;
      8: return 10'h155;
      10: return 10'h3e0;
      default: return 10'h000;
    endcase
  endfunction

  initial begin
    logic [12:0] ra [5];
    logic [7:0] rv [5];
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    seen = 1'h0;
    srst = 1'h1;
    ca = 10'h000;
    cb = 10'h000;
    void'($urandom(78));
    ra = '{ADDR_MODES, ADDR_CLOCK, ADDR_CLK_DIV, ADDR_TEST, ADDR_BIST};
    rv = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge ref_clk);
    #1 srst = 1'h0;
    host.tick(6);
    check({mode, 7'h00, dcs}, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      check(q, rv[i]);
    end
    wr(13'h020, 8'h5a);
    rd(13'h020);
    check(q, 8'h00);
    // Shadowed writes read back at once but stay off the outputs until the transfer
    v = 8'($urandom);
    wr(ADDR_MODES, v);
    wr(ADDR_CLOCK, 8'h01);
    check({mode, 7'h00, dcs}, 16'h8000);
    rd(ADDR_MODES);
    check(q, v);
    wr(ADDR_XFER, 8'h01);
    check({mode, 7'h00, dcs}, {v, 8'h01});
    // Strobe count over a span that every ratio divides
    for (int d = 7; d >= 0; d--) begin
      apply(ADDR_CLK_DIV, 8'(d));
      n = 0;
      repeat (840) begin
        @(posedge ref_clk);
        #2 if (strobe === 1'h1) n++;
      end
      check(16'(n), 16'(840 / (d + 1)));
    end
    wr(ADDR_CHAN_IDX, 8'h01);
    for (int c = 0; c < 14; c++) begin
      apply(ADDR_TEST, 8'(c));
      @(posedge ref_clk);
      #2 p = a_out;
      @(posedge ref_clk);
      #2 check(b_out, last_b);
      if (c == 0 || c > 12)
        check(a_out, last_a);
      else if (c inside {1, 2, 3, 8, 10})
        check(a_out, tm_exp(c));
      else if (c inside {4, 7, 9})
        check(a_out ^ p, 10'h3ff);
      else if (c == 11)
        check(16'($countones(a_out)), 16'h1);
      else
        check(a_out != p, 1'h1);
    end
    // Both channels, then B alone, then read-back picks A
    wr(ADDR_CHAN_IDX, 8'h03);
    apply(ADDR_TEST, 8'h02);
    check({a_out, 6'h00}, {10'h3ff, 6'h00});
    check(b_out, 10'h3ff);
    wr(ADDR_CHAN_IDX, 8'h02);
    apply(ADDR_TEST, 8'h03);
    check(a_out, 10'h3ff);
    check(b_out, 10'h000);
    wr(ADDR_CHAN_IDX, 8'h03);
    rd(ADDR_TEST);
    check(q, 8'h02);
    // Hold bits pin each sequence at its all-ones seed
    apply(ADDR_TEST, 8'h25);
    check(a_out, 10'h3ff);
    apply(ADDR_TEST, 8'h16);
    check(b_out, 10'h3fe);
    // Constant A data, so a seeded rerun must match
    seen = 1'h0;
    apply(ADDR_BIST, 8'h05);
    check(seen, 1'h1);
    check(busy, 1'h0);
    s1 = sig;
    apply(ADDR_BIST, 8'h00);
    seen = 1'h0;
    apply(ADDR_BIST, 8'h05);
    check(seen, 1'h1);
    check(sig, s1);
    // Without the seed bit the signature carries on from the last run
    apply(ADDR_BIST, 8'h00);
    seen = 1'h0;
    apply(ADDR_BIST, 8'h01);
    check(seen, 1'h1);
    check(sig == s1, 1'h0);
    results();
  end
endmodule
